// [verilog/hot_swap_fault_status_logic.sv]
// Fault decision, gate requests and status registers of the hot-swap block
`timescale 1ns/100ps
// What this block does
// - Breaker trip over chosen multiple: strong pulldown, fault timer runs
// - Below breaker threshold: strong pulldown off, limit loops steer gate
// - Timer trip while limiting after breaker: moderate pulldown turns on
// - Breaker event sets vendor and diag breaker bits, alert unless masked
// - Setup register override picks breaker multiple; strap used otherwise
// - Power over threshold: regulate gate and run the fault timer
// - Power limit past timeout: overcurrent, summary, diag bits, alert
// - Undervoltage holds gate off; charge only after insertion delay
// - Undervoltage hysteresis on while low; overvoltage source off then
// - Undervoltage after power-up sets input, summary, diag bits, alert
// - Overvoltage: moderate pulldown; gate re-enabled when it falls back
// - Overvoltage hysteresis source follows overvoltage comparator
// - Overvoltage sets the input overvoltage status bit
// - Power good released when feedback high; feedback hysteresis follows
// - Power good forced low during undervoltage or overvoltage
// - Power good state readable in status word and diagnostic word
// - Diode excitation pulses high once per millisecond, low otherwise
// - Temperature read command returns the measured remote temperature
// - Alert above warning limit; gate disabled above fault limit
// - Host rewrites temperature limits; new limits replace defaults
// - After power-on, alert low and preset bit set until clear-faults
module hot_swap_fault_status_logic #(
    parameter int DIODE_PERIOD_CYCLES = hsw_pkg::DIODE_PERIOD_CYC
) (
    input  wire logic        i_clk,                // System clock
    input  wire logic        i_nrst,               // Sync reset, low
    input  wire logic        i_cmd_valid,          // Command strobe
    input  wire logic        i_cmd_write,          // 1 write, 0 read
    input  wire logic [7:0]  i_cmd_code,           // Command code
    input  wire logic [15:0] i_cmd_wdata,          // Write data
    output logic      [15:0] o_cmd_rdata,          // Read data
    output logic             o_cmd_done,           // Answer pulse
    output logic             o_cmd_unmapped,       // Bad command
    input  wire logic        i_breaker_multiple_strap, // Strap, 1 high
    input  wire logic        i_cb_over_low,        // Above low multiple
    input  wire logic        i_cb_over_high,       // Above high multiple
    input  wire logic        i_cl_active,          // Current limiting
    input  wire logic        i_pl_active,          // Power at limit
    input  wire logic        i_timer_trip,         // Timer at trip level
    input  wire logic        i_insert_done,        // Insertion delay over
    input  wire logic        i_uv_below,           // Undervoltage input low
    input  wire logic        i_ov_above,           // Overvoltage input high
    input  wire logic        i_fb_above,           // Feedback above level
    input  wire logic        i_temp_valid,         // New temperature
    input  wire logic [15:0] i_temp_value,         // Temperature, signed
    output logic             o_gate_strong_pd,     // Strong pulldown
    output logic             o_gate_moderate_pd,   // Moderate pulldown
    output logic             o_gate_charge,        // Gate charge current
    output logic             o_timer_run,          // Fault timer charge
    output logic             o_breaker_sel_high,   // High multiple chosen
    output logic             o_uv_hyst_en,         // UV hysteresis source
    output logic             o_ov_hyst_en,         // OV hysteresis source
    output logic             o_fb_hyst_en,         // FB hysteresis source
    input  wire logic        i_power_good_out_pin, // Pin level
    output logic             o_power_good_out,     // Pin drive value
    output logic             o_power_good_out_oe,  // Pulls pin low
    input  wire logic        i_alert_out_n_pin,    // Pin level
    output logic             o_alert_out_n,        // Pin drive value
    output logic             o_alert_out_n_oe,     // Pulls pin low
    output logic             o_diode_high          // High excitation
);

    typedef struct packed {
        hsw_pkg::gate_mode_t mode;
        logic                powered;
        logic                f_brk;
        logic                f_oc;
        logic                f_uv;
        logic                f_ov;
        logic                f_otw;
        logic                f_otf;
        logic                f_preset;
        logic [15:0]         ot_fault;
        logic [15:0]         ot_warn;
        logic [15:0]         mask;
        logic [15:0]         temp;
        logic [7:0]          setup;
        logic [16:0]         dcnt;
        logic                g_strong;
        logic                g_mod;
        logic                g_chg;
        logic                t_run;
        logic                uv_h;
        logic                ov_h;
        logic                fb_h;
        logic                pgood;
        logic                alert;
        logic                diode;
        logic [15:0]         rdata;
        logic                done;
        logic                unmapped;
    } state_t;

    state_t      q;
    state_t      d;
    logic        sel;
    logic        brk;
    logic        otw_now;
    logic        otf_now;
    logic        wr;
    logic        rd;
    logic        clr;
    logic        trip;

    // Diagnostic word from a state copy, power good optional
    function automatic logic [15:0] diag_of(input state_t s,
                                            input logic   with_pg);
        logic [15:0] v;
        v = 16'h0000;
        v[hsw_pkg::DG_PGOOD]  = s.pgood & with_pg;
        v[hsw_pkg::DG_OTF]    = s.f_otf;
        v[hsw_pkg::DG_OTW]    = s.f_otw;
        v[hsw_pkg::DG_OCOP]   = s.f_oc;
        v[hsw_pkg::DG_UV]     = s.f_uv;
        v[hsw_pkg::DG_OV]     = s.f_ov;
        v[hsw_pkg::DG_BRK]    = s.f_brk;
        v[hsw_pkg::DG_PRESET] = s.f_preset;
        return v;
    endfunction : diag_of

    // Breaker multiple select and comparator pick
    assign sel = q.setup[hsw_pkg::SET_CB_OVR] ?
                 q.setup[hsw_pkg::SET_CB_VAL] :
                 i_breaker_multiple_strap;
    assign brk = sel ? i_cb_over_high : i_cb_over_low;

    // Temperature limit compare against live limits
    assign otw_now = $signed(q.temp) > $signed(q.ot_warn);
    assign otf_now = $signed(q.temp) > $signed(q.ot_fault);

    // Command decode
    assign wr   = i_cmd_valid & i_cmd_write;
    assign rd   = i_cmd_valid & ~i_cmd_write;
    assign clr  = wr & (i_cmd_code == hsw_pkg::CMD_CLEAR_FAULTS);
    assign trip = (q.mode == hsw_pkg::ST_RUN) & i_timer_trip &
                  (i_cl_active | i_pl_active);

    // Next state: gate, flags, registers and answers
    always_comb begin
        d = q;
        d.done     = 1'b0;
        d.unmapped = 1'b0;
        // Gate mode sequencing
        case (q.mode)
            hsw_pkg::ST_INSERT: begin
                if (i_insert_done) begin
                    d.mode    = hsw_pkg::ST_RUN;
                    d.powered = 1'b1;
                end
            end
            hsw_pkg::ST_RUN: begin
                if (trip) begin
                    d.mode = hsw_pkg::ST_LATCHED;
                end
            end
            default: begin
                if (i_uv_below) begin
                    d.mode = hsw_pkg::ST_INSERT;
                end
            end
        endcase
        // Gate requests
        d.g_strong = brk;
        d.g_mod    = (q.mode != hsw_pkg::ST_RUN) | i_uv_below |
                     i_ov_above | otf_now;
        d.g_chg    = (q.mode == hsw_pkg::ST_RUN) & ~i_uv_below &
                     ~i_ov_above & ~otf_now & ~brk;
        d.t_run    = (q.mode == hsw_pkg::ST_RUN) &
                     (brk | i_cl_active | i_pl_active);
        // Hysteresis sources and power good
        d.uv_h  = i_uv_below;
        d.ov_h  = i_ov_above & ~i_uv_below;
        d.fb_h  = i_fb_above;
        d.pgood = i_fb_above & ~i_uv_below & ~i_ov_above;
        // Sticky flags, a set in the clear cycle wins
        d.f_brk    = (q.f_brk & ~clr) | brk;
        d.f_oc     = (q.f_oc & ~clr) | trip;
        d.f_uv     = (q.f_uv & ~clr) | (i_uv_below & q.powered);
        d.f_ov     = (q.f_ov & ~clr) | i_ov_above;
        d.f_otw    = (q.f_otw & ~clr) | otw_now;
        d.f_otf    = (q.f_otf & ~clr) | otf_now;
        d.f_preset = q.f_preset & ~clr;
        // Temperature capture
        if (i_temp_valid) begin
            d.temp = i_temp_value;
        end
        // Diode excitation period counter
        d.diode = 1'b0;
        if (q.dcnt == 17'(DIODE_PERIOD_CYCLES - 1)) begin
            d.dcnt  = 17'h00000;
            d.diode = 1'b1;
        end else begin
            d.dcnt = q.dcnt + 17'h00001;
        end
        // Register writes
        if (wr) begin
            d.done = 1'b1;
            if (i_cmd_code == hsw_pkg::CMD_OT_FAULT) begin
                d.ot_fault = i_cmd_wdata;
            end else if (i_cmd_code == hsw_pkg::CMD_OT_WARN) begin
                d.ot_warn = i_cmd_wdata;
            end else if (i_cmd_code == hsw_pkg::CMD_MASK) begin
                d.mask = i_cmd_wdata;
            end else if (i_cmd_code == hsw_pkg::CMD_SETUP) begin
                d.setup = i_cmd_wdata[7:0];
            end else if (i_cmd_code != hsw_pkg::CMD_CLEAR_FAULTS) begin
                d.unmapped = 1'b1;
            end
        end
        // Register reads
        if (rd) begin
            d.done  = 1'b1;
            d.rdata = 16'h0000;
            if (i_cmd_code == hsw_pkg::CMD_OT_FAULT) begin
                d.rdata = q.ot_fault;
            end else if (i_cmd_code == hsw_pkg::CMD_OT_WARN) begin
                d.rdata = q.ot_warn;
            end else if (i_cmd_code == hsw_pkg::CMD_STATUS_WORD) begin
                d.rdata[hsw_pkg::SW_INPUT] = q.f_oc | q.f_uv | q.f_ov;
                d.rdata[hsw_pkg::SW_PG_N]  = ~q.pgood;
                d.rdata[hsw_pkg::SW_TEMP]  = q.f_otw | q.f_otf;
            end else if (i_cmd_code == hsw_pkg::CMD_STATUS_INPUT) begin
                d.rdata[hsw_pkg::IN_OC] = q.f_oc;
                d.rdata[hsw_pkg::IN_UV] = q.f_uv;
                d.rdata[hsw_pkg::IN_OV] = q.f_ov;
            end else if (i_cmd_code == hsw_pkg::CMD_VENDOR_STATUS) begin
                d.rdata[hsw_pkg::VEN_BRK]    = q.f_brk;
                d.rdata[hsw_pkg::VEN_PRESET] = q.f_preset;
            end else if (i_cmd_code == hsw_pkg::CMD_READ_TEMP) begin
                d.rdata = q.temp;
            end else if (i_cmd_code == hsw_pkg::CMD_MASK) begin
                d.rdata = q.mask;
            end else if (i_cmd_code == hsw_pkg::CMD_SETUP) begin
                d.rdata = {8'h00, q.setup};
            end else if (i_cmd_code == hsw_pkg::CMD_DIAG) begin
                d.rdata = diag_of(q, 1'b1);
            end else begin
                d.unmapped = 1'b1;
            end
        end
        // Alert from next flags, held while any unmasked flag stays
        d.alert = |(diag_of(d, 1'b0) & ~q.mask);
        // Synchronous reset values
        if (!i_nrst) begin
            d          = '0;
            d.mode     = hsw_pkg::ST_INSERT;
            d.f_preset = 1'b1;
            d.alert    = 1'b1;
            d.g_mod    = 1'b1;
            d.ot_fault = hsw_pkg::OT_FAULT_RST;
            d.ot_warn  = hsw_pkg::OT_WARN_RST;
            d.mask     = hsw_pkg::MASK_RST;
            d.temp     = hsw_pkg::TEMP_RST;
            d.setup    = hsw_pkg::SETUP_RST;
        end
    end

    // State register
    always_ff @(posedge i_clk) begin
        q <= d;
    end

    // Outputs from the state register, pin drive values tied low; breaker select decoded from setup and strap
    assign o_cmd_rdata         = q.rdata;
    assign o_cmd_done          = q.done;
    assign o_cmd_unmapped      = q.unmapped;
    assign o_gate_strong_pd    = q.g_strong;
    assign o_gate_moderate_pd  = q.g_mod;
    assign o_gate_charge       = q.g_chg;
    assign o_timer_run         = q.t_run;
    assign o_breaker_sel_high  = sel;
    assign o_uv_hyst_en        = q.uv_h;
    assign o_ov_hyst_en        = q.ov_h;
    assign o_fb_hyst_en        = q.fb_h;
    assign o_power_good_out    = 1'b0;
    assign o_power_good_out_oe = ~q.pgood;
    assign o_alert_out_n       = 1'b0;
    assign o_alert_out_n_oe    = q.alert;
    assign o_diode_high        = q.diode;

    // Checks on the block's own behaviour
    a_breaker_pd: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        brk |=> o_gate_strong_pd && !o_gate_charge)
        else $error("breaker did not pull gate strongly");
    a_breaker_rel: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        $fell(brk) |=> !o_gate_strong_pd)
        else $error("strong pulldown not released");
    a_trip_off: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        trip |=> ##1 o_gate_moderate_pd && !o_gate_charge)
        else $error("timer trip left gate on");
    a_breaker_flag: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        brk && !q.mask[hsw_pkg::DG_BRK] |=> q.f_brk && o_alert_out_n_oe)
        else $error("breaker flag or alert missing");
    a_setup_ovr: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        q.setup[hsw_pkg::SET_CB_OVR] |->
        o_breaker_sel_high == q.setup[hsw_pkg::SET_CB_VAL])
        else $error("setup override ignored");
    a_power_timer: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        q.mode == hsw_pkg::ST_RUN && i_pl_active |=> o_timer_run)
        else $error("power limit did not run timer");
    a_oc_flag: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        trip |=> q.f_oc && q.mode == hsw_pkg::ST_LATCHED)
        else $error("overcurrent flag not set");
    a_uv_gate: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        i_uv_below |=> o_gate_moderate_pd && !o_gate_charge)
        else $error("gate on during undervoltage");
    a_uv_hyst: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        i_uv_below |=> o_uv_hyst_en && !o_ov_hyst_en)
        else $error("hysteresis sources wrong");
    a_pgood_force: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        i_uv_below || i_ov_above |=> o_power_good_out_oe)
        else $error("power good not forced low");
    a_diode_pulse: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        o_diode_high |=> !o_diode_high [*8])
        else $error("diode pulse too frequent");
    a_alert_hold: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        o_alert_out_n_oe && !clr && $stable(q.mask) |=> o_alert_out_n_oe)
        else $error("alert dropped without clear");
    a_preset_rst: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        $rose(i_nrst) |-> q.f_preset && o_alert_out_n_oe)
        else $error("preset bit not set after reset");

endmodule : hot_swap_fault_status_logic

// [verilog/hsw_pkg.sv]
// Command codes, field positions, reset values and timing counts
package hsw_pkg;
    // Management bus command codes
    localparam logic [7:0] CMD_OT_FAULT      = 8'h4f;
    localparam logic [7:0] CMD_OT_WARN       = 8'h51;
    localparam logic [7:0] CMD_STATUS_WORD   = 8'h79;
    localparam logic [7:0] CMD_STATUS_INPUT  = 8'h7c;
    localparam logic [7:0] CMD_VENDOR_STATUS = 8'h80;
    localparam logic [7:0] CMD_READ_TEMP     = 8'h8d;
    localparam logic [7:0] CMD_MASK          = 8'hd8;
    localparam logic [7:0] CMD_SETUP         = 8'hd9;
    localparam logic [7:0] CMD_DIAG          = 8'he1;
    localparam logic [7:0] CMD_CLEAR_FAULTS  = 8'h03;

    // Reset values, temperature in whole degrees
    localparam logic [15:0] OT_FAULT_RST = 16'h0096;
    localparam logic [15:0] OT_WARN_RST  = 16'h007d;
    localparam logic [15:0] MASK_RST     = 16'h0000;
    localparam logic [15:0] TEMP_RST     = 16'h0000;
    localparam logic [7:0]  SETUP_RST    = 8'h00;

    // Field positions
    localparam int VEN_PRESET = 0;
    localparam int VEN_BRK    = 1;
    localparam int IN_OC      = 1;
    localparam int IN_UV      = 4;
    localparam int IN_OV      = 7;
    localparam int SW_TEMP    = 2;
    localparam int SW_PG_N    = 11;
    localparam int SW_INPUT   = 13;
    localparam int DG_PGOOD   = 0;
    localparam int DG_OTF     = 1;
    localparam int DG_OTW     = 2;
    localparam int DG_OCOP    = 3;
    localparam int DG_UV      = 4;
    localparam int DG_OV      = 5;
    localparam int DG_BRK     = 6;
    localparam int DG_PRESET  = 7;
    localparam int SET_CB_OVR = 7;
    localparam int SET_CB_VAL = 6;

    // Diode excitation timing
    localparam int CLK_MHZ          = 100;
    localparam int DIODE_PERIOD_US  = 1000;
    localparam int DIODE_PERIOD_CYC = DIODE_PERIOD_US * CLK_MHZ;
    localparam int DIODE_CNT_W      = 17;

    typedef enum logic [1:0] {ST_INSERT, ST_RUN, ST_LATCHED} gate_mode_t;
endpackage : hsw_pkg

// [tb/hsw_host_model.sv]
// Management host model driving the command port of the hot-swap block
`timescale 1ns/100ps
module hsw_host_model (
    input  wire logic        i_clk,      // System clock
    output logic             o_valid,    // Command strobe
    output logic             o_write,    // 1 write, 0 read
    output logic [7:0]       o_code,     // Command code
    output logic [15:0]      o_wdata,    // Write data
    input  wire logic [15:0] i_rdata,    // Read data
    input  wire logic        i_done,     // Answer pulse
    input  wire logic        i_unmapped  // Refusal pulse
);
    // Idle bus before the first command
    initial begin
        o_valid = 1'b0;
        o_write = 1'b0;
        o_code  = 8'h00;
        o_wdata = 16'h0000;
    end

    // One command: strobe for one cycle, answer taken one cycle later
    task automatic xfer(input logic w, input logic [7:0] c,
                        input logic [15:0] dat, output logic [15:0] rd,
                        output logic dn, output logic un);
        @(negedge i_clk);
        o_valid = 1'b1;
        o_write = w;
        o_code  = c; // Limit rewrites travel here
        o_wdata = dat;
        @(negedge i_clk);
        o_valid = 1'b0;
        o_code  = ~c; // Released lines show no stale value
        o_wdata = ~dat;
        rd = i_rdata;
        dn = i_done;
        un = i_unmapped;
    endtask : xfer
endmodule : hsw_host_model

// [tb/hot_swap_fault_status_logic_tb_top.sv]
// Self-checking bench for the hot-swap fault and status block
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module hot_swap_fault_status_logic_tb_top;
    logic        clk, nrst, strap, cbl, cbh, cl, pl, trip, ins, uv, ov, fb, tv;
    logic        valid, wr, done, unm, sel_h, spd, mpd, chg, trun, uvh, ovh;
    logic        fbh, pg, pg_oe, al, al_oe, dio, d, u;
    logic [7:0]  code;
    logic [15:0] wdata, rdata, tval, r;
    wire         pgp = pg_oe ? pg : 1'b1; // Pull-up on open-drain pins
    wire         alp = al_oe ? al : 1'b1;
    int n_mismatch, comparisons, seed, k, rv, lf, lw, mk, su, tp;
    int pre, brk, oc, fuv, fov, otf, otw, pgm;
    int codes[9] = '{'h4f, 'h51, 'h79, 'h7c, 'h80, 'h8d, 'hd8, 'hd9, 'he1};

    hsw_host_model host (.i_clk(clk), .o_valid(valid), .o_write(wr),
        .o_code(code), .o_wdata(wdata), .i_rdata(rdata), .i_done(done),
        .i_unmapped(unm));
    hot_swap_fault_status_logic #(.DIODE_PERIOD_CYCLES(20)) dut (
        .i_clk(clk), .i_nrst(nrst), .i_cmd_valid(valid), .i_cmd_write(wr),
        .i_cmd_code(code), .i_cmd_wdata(wdata), .o_cmd_rdata(rdata),
        .o_cmd_done(done), .o_cmd_unmapped(unm),
        .i_breaker_multiple_strap(strap), .i_cb_over_low(cbl),
        .i_cb_over_high(cbh), .i_cl_active(cl), .i_pl_active(pl),
        .i_timer_trip(trip), .i_insert_done(ins), .i_uv_below(uv),
        .i_ov_above(ov), .i_fb_above(fb), .i_temp_valid(tv),
        .i_temp_value(tval), .o_gate_strong_pd(spd), .o_gate_moderate_pd(mpd),
        .o_gate_charge(chg), .o_timer_run(trun), .o_breaker_sel_high(sel_h),
        .o_uv_hyst_en(uvh), .o_ov_hyst_en(ovh), .o_fb_hyst_en(fbh),
        .i_power_good_out_pin(pgp), .o_power_good_out(pg),
        .o_power_good_out_oe(pg_oe), .i_alert_out_n_pin(alp),
        .o_alert_out_n(al), .o_alert_out_n_oe(al_oe), .o_diode_high(dio));

    // Clock, 10 ns period
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Reference model of the readable registers
    function automatic int exp_rd(input int c);
        int e1 = pgm | otf<<1 | otw<<2 | oc<<3 | fuv<<4 | fov<<5
                 | brk<<6 | pre<<7;
        case (c)
            'h4f: return lf;
            'h51: return lw;
            'hd8: return mk;
            'hd9: return su;
            'h8d: return tp;
            'h80: return pre | brk<<1;
            'h7c: return oc<<1 | fuv<<4 | fov<<7;
            'h79: return (oc | fuv | fov)<<13 | (1 - pgm)<<11 | (otw | otf)<<2;
            default: return e1;
        endcase
    endfunction : exp_rd

    // Model update from live comparator levels
    task automatic upd();
        pgm = fb && !uv && !ov;
        if (uv) fuv = 1;
        if (ov) fov = 1;
        if (tp > lw) otw = 1;
        if (tp > lf) otf = 1;
    endtask : upd

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    task automatic rd(input int c);
        int e = exp_rd(c);
        host.xfer(1'b0, c[7:0], 16'h0000, r, d, u);
        `CHK({d, u, r}, {2'b10, e[15:0]})
    endtask : rd

    task automatic w(input int c, input int v);
        host.xfer(1'b1, c[7:0], v[15:0], r, d, u);
        `CHK({d, u}, 2'b10)
        if (c == 'h4f) lf = v;
        if (c == 'h51) lw = v;
        if (c == 'hd8) mk = v;
        if (c == 'hd9) su = v & 'hff;
    endtask : w

    task automatic clr();
        w('h03, 0);
        {pre, brk, oc, fuv, fov, otf, otw} = '0;
        upd();
    endtask : clr

    // Hysteresis, power good and alert pins against the model
    task automatic pins();
        `CHK(uvh, uv)
        `CHK(ovh, ov & !uv)
        `CHK(fbh, fb)
        `CHK(pg_oe, !(fb & !uv & !ov))
        `CHK(al_oe, (exp_rd('he1) & 'hfe & ~mk) != 0)
        `CHK(pgp, fb & !uv & !ov)
        `CHK(alp, (exp_rd('he1) & 'hfe & ~mk) == 0)
    endtask : pins

    task automatic end_sim();
        $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim

    // Hang guard
    initial begin
        #400000;
        n_mismatch++;
        $display("timeout");
        end_sim();
    end

    // Main sequence
    initial begin
        {nrst, strap, cbl, cbh, cl, pl, trip, ins, uv, ov, fb, tv} = '0;
        tval = 16'h0000;
        seed = 20;
        {n_mismatch, comparisons, tp, mk, su, brk, oc, fuv, fov, otf, otw} = '0;
        lf = 'h96;
        lw = 'h7d;
        pre = 1;
        cyc(10);
        nrst = 1'b1;
        upd();
        `CHK({al_oe, mpd, chg, spd}, 4'b1100)
        foreach (codes[i]) rd(codes[i]);
        clr();
        pins();
        $display("reset test done");
        ins = 1'b1;
        cyc(3);
        `CHK({chg, mpd}, 2'b10)
        uv = 1'b1;
        cyc(2);
        upd();
        `CHK(chg, 1'b0)
        rd('h7c);
        for (k = 0; k < 12; k++) begin
            rv = $random(seed);
            {uv, ov, fb} = rv[2:0];
            cyc(3);
            upd();
            pins();
            rd('he1);
            rd('h79);
        end
        {uv, ov, fb} = 3'b001;
        cyc(3);
        upd();
        clr();
        pins();
        $display("comparator test done");
        for (k = 0; k < 2; k++) begin
            strap = k[0];
            cyc(1);
            `CHK(sel_h, k[0])
        end
        strap = 1'b0;
        cbl = 1'b1;
        cyc(2);
        brk = 1;
        `CHK({spd, trun, chg}, 3'b110)
        cbl = 1'b0;
        cyc(2);
        `CHK(spd, 1'b0)
        rd('h80);
        pins();
        w('hd8, 'h0040);
        cyc(1);
        pins();
        w('hd9, 'h00c0);
        cbl = 1'b1;
        cyc(2);
        `CHK({sel_h, spd}, 2'b10)
        cbh = 1'b1;
        cyc(2);
        `CHK(spd, 1'b1)
        {cbl, cbh} = 2'b00;
        w('hd9, 0);
        w('hd8, 0);
        $display("breaker test done");
        pl = 1'b1;
        cyc(2);
        `CHK(trun, 1'b1)
        trip = 1'b1;
        cyc(3);
        oc = 1;
        `CHK({mpd, chg}, 2'b10)
        {pl, trip} = 2'b00;
        rd('h7c);
        rd('h79);
        rd('he1);
        uv = 1'b1;
        cyc(2);
        upd();
        uv = 1'b0;
        cyc(3);
        upd();
        clr();
        $display("power limit test done");
        tval = 16'h0082;
        tv = 1'b1;
        cyc(1);
        tv = 1'b0;
        tp = 'h82;
        cyc(1);
        upd();
        rd('h8d);
        rd('he1);
        pins();
        w('h4f, 'h0064);
        cyc(2);
        upd();
        rd('he1);
        `CHK(chg, 1'b0)
        tval = 16'h0014;
        tv = 1'b1;
        cyc(1);
        tv = 1'b0;
        tp = 'h14;
        w('h4f, 'h0096);
        clr();
        cyc(2);
        pins();
        `CHK(chg, 1'b1)
        w('h51, 'h000a);
        cyc(2);
        upd();
        rd('he1);
        $display("temperature test done");
        host.xfer(1'b0, 8'h00, 16'h0000, r, d, u);
        `CHK({d, u}, 2'b11)
        host.xfer(1'b1, 8'h79, 16'h1234, r, d, u);
        `CHK({d, u}, 2'b11)
        k = 0;
        while (dio !== 1'b1 && k < 60) begin
            cyc(1);
            k++;
        end
        `CHK(dio, 1'b1)
        cyc(1);
        k = 1;
        while (dio !== 1'b1 && k < 60) begin
            cyc(1);
            k++;
        end
        `CHK(k, 20)
        $display("refusal and diode test done");
        end_sim();
    end
endmodule : hot_swap_fault_status_logic_tb_top
